// ### src/stp_pkg.sv
// package: constants and carrier types for the scan test port mode control
// Behaviour
// RULE1: blown program fuse selects dedicated, else flexible
// RULE2: dedicated mode reserves clock, data pins for scan
// RULE3: flexible mode lets scan pins serve user I/O
// RULE4: tester holds select high; low starts test
// RULE5: dedicated mode enables pull-ups on select, data-in
// RULE6: dedicated mode runs standard tap controller from select
// RULE7: tool picks nets; device routes them to probes
// RULE8: active probing takes pins from user I/O
// RULE9: blown security fuse disables the probe circuitry
// RULE10: flexible pins switch only after test starts
`default_nettype none
package stp_pkg;
  // reset value of every control flop
  localparam logic       RST_BIT     = 1'b0;
  // probe selector layout: two net indices
  localparam int         SEL_W       = 4;
  localparam int         NET_W       = 16;
  localparam logic [3:0] TAP_IR_PROBE = 4'h8; // arbitrary probe instruction
  localparam int         IR_W        = 4;
  localparam int         DR_W        = 2 * SEL_W + 1;
  // user side pins of the three shared scan pins
  typedef struct packed {
    logic clk_o; logic clk_oe;
    logic din_o; logic din_oe;
    logic dout_o; logic dout_oe;
  } stp_user_pins_t;
  typedef struct packed {
    logic probe_en;
    logic [SEL_W-1:0] sel_a;
    logic [SEL_W-1:0] sel_b;
  } stp_probe_cfg_t;
endpackage : stp_pkg
`default_nettype wire

// ### src/stp_tap.sv
// standard test access port controller with a probe select register
`default_nettype none
module stp_tap (
  input  wire logic                  i_tck,
  input  wire logic                  i_trst,
  input  wire logic                  i_tms,
  input  wire logic                  i_tdi,
  output logic                       o_tdo,
  output logic                       o_tdo_oe,
  output logic                       o_active,
  output stp_pkg::stp_probe_cfg_t    o_cfg
);
  typedef enum logic [3:0] {
    TLR, RTI, SDS, CDR, SDR, E1D, PDR, E2D, UDR,
    SIS, CIR, SIR, E1I, PIR, E2I, UIR
  } stp_tap_t;
  stp_tap_t state;
  stp_tap_t next_state;
  logic [stp_pkg::IR_W-1:0] ir;
  logic [stp_pkg::IR_W-1:0] next_ir;
  logic [stp_pkg::IR_W-1:0] irs;
  logic [stp_pkg::IR_W-1:0] next_irs;
  logic [stp_pkg::DR_W-1:0] drs;
  logic [stp_pkg::DR_W-1:0] next_drs;
  stp_pkg::stp_probe_cfg_t cfg;
  stp_pkg::stp_probe_cfg_t next_cfg;
  logic next_tdo;
  logic next_oe;
  logic tdo;
  logic oe;
  ////////////////////////////////////////////////////////////////////////
  // standard state transitions on select
  always_comb begin
    unique case (state)
      TLR: next_state = i_tms ? TLR : RTI; // RULE6
      RTI: next_state = i_tms ? SDS : RTI;
      SDS: next_state = i_tms ? SIS : CDR;
      CDR: next_state = i_tms ? E1D : SDR;
      SDR: next_state = i_tms ? E1D : SDR;
      E1D: next_state = i_tms ? UDR : PDR;
      PDR: next_state = i_tms ? E2D : PDR;
      E2D: next_state = i_tms ? UDR : SDR;
      UDR: next_state = i_tms ? SDS : RTI;
      SIS: next_state = i_tms ? TLR : CIR;
      CIR: next_state = i_tms ? E1I : SIR;
      SIR: next_state = i_tms ? E1I : SIR;
      E1I: next_state = i_tms ? UIR : PIR;
      PIR: next_state = i_tms ? E2I : PIR;
      E2I: next_state = i_tms ? UIR : SIR;
      UIR: next_state = i_tms ? SDS : RTI;
      // reset pin tied low at the top: an unknown power-up state falls back to reset
      default: next_state = TLR;
    endcase
  end
  // shift paths and update of the probe selector
  always_comb begin
    next_ir  = ir;
    next_irs = irs;
    next_drs = drs;
    next_cfg = cfg;
    if (state == TLR) begin
      next_ir  = '0;
      next_cfg = '0;
    end
    if (state == CIR) next_irs = ir;
    if (state == SIR) next_irs = {i_tdi, irs[stp_pkg::IR_W-1:1]};
    if (state == UIR) next_ir = irs;
    if (state == CDR) next_drs = cfg;
    if (state == SDR) next_drs = {i_tdi, drs[stp_pkg::DR_W-1:1]};
    if (state == UDR && ir == stp_pkg::TAP_IR_PROBE) begin
      next_cfg = drs; // RULE7
    end
  end
  // tdo changes on falling edge, enabled only while shifting
  always_comb begin
    next_oe  = (state == SDR) || (state == SIR);
    next_tdo = (state == SIR) ? irs[0] : drs[0];
  end
  always_ff @(posedge i_tck) begin
    if (i_trst) begin
      state <= TLR;
      ir    <= '0;
      irs   <= '0;
      drs   <= '0;
      cfg   <= '0;
    end else begin
      state <= next_state;
      ir    <= next_ir;
      irs   <= next_irs;
      drs   <= next_drs;
      cfg   <= next_cfg;
    end
  end
  always_ff @(negedge i_tck) begin
    if (i_trst) begin
      tdo <= stp_pkg::RST_BIT;
      oe  <= stp_pkg::RST_BIT;
    end else begin
      tdo <= next_tdo;
      oe  <= next_oe;
    end
  end
  assign o_tdo    = tdo;
  assign o_tdo_oe = oe;
  assign o_active = (state != TLR); // RULE4
  assign o_cfg    = cfg;
endmodule : stp_tap
`default_nettype wire

// ### src/stp_mode_ctrl.sv
// top: pin mode control, tap and probe routing for the scan port
`default_nettype none
module stp_mode_ctrl (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_tck,
  input  wire logic                    i_fuse_prog,
  input  wire logic                    i_fuse_sec,
  input  wire logic                    i_tms,
  input  wire logic                    i_tdi,
  input  wire logic [stp_pkg::NET_W-1:0] i_nets,
  input  wire stp_pkg::stp_user_pins_t i_user,
  output logic                         o_tdo,
  output logic                         o_tdo_oe,
  output logic                         o_tck_oe,
  output logic                         o_tdi_o,
  output logic                         o_tdi_oe,
  output logic                         o_tck_o,
  output logic                         o_pullup_en,
  output logic                         o_dedicated,
  output logic                         o_test_active,
  output logic                         o_user_tck,
  output logic                         o_user_tdi,
  output logic                         o_probe_out_a,
  output logic                         o_probe_out_b
);
  logic                    tdo_t;
  logic                    oe_t;
  logic                    act_t;
  stp_pkg::stp_probe_cfg_t cfg_t;
  logic [2:0] fs_p;
  logic [2:0] fs_s;
  logic [1:0] act_s;
  logic [1:0] en_s;
  logic [2*stp_pkg::SEL_W-1:0] sel_q;
  logic [2*stp_pkg::SEL_W-1:0] next_sel_q;
  logic next_ded;
  logic next_act;
  logic next_probe;
  logic ded;
  logic act;
  logic probe;
  logic next_pa;
  logic next_pb;
  logic [5:0] next_pins;
  logic [5:0] pins;
  ////////////////////////////////////////////////////////////////////////
  // tap parks itself in reset by select held high; no link-side reset
  stp_tap u_tap (
    .i_tck    (i_tck),
    .i_trst   (1'b0),
    .i_tms    (i_tms),
    .i_tdi    (i_tdi),
    .o_tdo    (tdo_t),
    .o_tdo_oe (oe_t),
    .o_active (act_t),
    .o_cfg    (cfg_t)
  );
  ////////////////////////////////////////////////////////////////////////
  // two-flop crossings: fuses, tap active, probe enable
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fs_p  <= '0;
      fs_s  <= '0;
      act_s <= '0;
      en_s  <= '0;
      sel_q <= '0;
    end else begin
      fs_p  <= {fs_p[1:0], i_fuse_prog};
      fs_s  <= {fs_s[1:0], i_fuse_sec};
      act_s <= {act_s[0], act_t};
      en_s  <= {en_s[0], cfg_t.probe_en};
      sel_q <= next_sel_q;
    end
  end
  // selector is quasi-static; take it only once enable has settled
  always_comb begin
    next_sel_q = sel_q;
    if (en_s[1] && fs_p[2] == fs_p[1]) begin
      next_sel_q = {cfg_t.sel_a, cfg_t.sel_b};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // mode decisions
  always_comb begin
    next_ded   = fs_p[1];                         // RULE1
    next_act   = fs_p[1] | act_s[1];              // RULE2 RULE10
    next_probe = act_s[1] & en_s[1] & ~fs_s[1];   // RULE9
    next_pa    = next_probe & i_nets[sel_q[7:4]];  // RULE7
    next_pb    = next_probe & i_nets[sel_q[3:0]];  // RULE7
    if (next_act || next_probe) begin
      next_pins = 6'h00;                          // RULE8 RULE2
    end else begin
      next_pins = {i_user.clk_o, i_user.clk_oe, i_user.din_o,
                   i_user.din_oe, i_user.dout_o, i_user.dout_oe}; // RULE3
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ded   <= stp_pkg::RST_BIT;
      act   <= stp_pkg::RST_BIT;
      probe <= stp_pkg::RST_BIT;
      o_probe_out_a <= stp_pkg::RST_BIT;
      o_probe_out_b <= stp_pkg::RST_BIT;
      pins  <= '0;
    end else begin
      ded   <= next_ded;
      act   <= next_act;
      probe <= next_probe;
      o_probe_out_a <= next_pa;
      o_probe_out_b <= next_pb;
      pins  <= next_pins;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // pin drive; tdo comes from the tap's falling-edge flop while the test is active, else from the user dout pins
  assign o_dedicated   = ded;
  assign o_test_active = act;
  assign o_pullup_en   = ded;                      // RULE5
  assign o_tck_o       = pins[5];
  assign o_tck_oe      = pins[4];
  assign o_tdi_o       = pins[3];
  assign o_tdi_oe      = pins[2];
  assign o_tdo         = act ? tdo_t : pins[1];
  assign o_tdo_oe      = act ? oe_t : pins[0];
  assign o_user_tck    = 1'b0;
  assign o_user_tdi    = probe;
endmodule : stp_mode_ctrl
`default_nettype wire

// ### verif/stp_mode_ctrl_properties.sv
// checker: port level properties of the scan port mode control
`default_nettype none
module stp_mode_props (
  input wire logic                    i_clk,
  input wire logic                    i_rst,
  input wire logic                    i_fuse_prog,
  input wire logic                    i_fuse_sec,
  input wire logic                    i_tms,
  input wire stp_pkg::stp_user_pins_t i_user,
  input wire logic                    o_tck_o,
  input wire logic                    o_tck_oe,
  input wire logic                    o_tdi_o,
  input wire logic                    o_tdi_oe,
  input wire logic                    o_pullup_en,
  input wire logic                    o_dedicated,
  input wire logic                    o_test_active,
  input wire logic                    o_user_tdi,
  input wire logic                    o_probe_out_a,
  input wire logic                    o_probe_out_b
);
  logic [7:0] tms_age;
  logic [7:0] next_tms_age;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  //////////////////////////////////////////////////////////////////////////
  // cycles since the select pin was last low, saturating
  always_comb begin
    next_tms_age = tms_age;
    if (!i_tms) next_tms_age = 8'h00;
    else if (tms_age != 8'hff) next_tms_age = tms_age + 8'h01;
  end
  always_ff @(posedge i_clk) tms_age <= i_rst ? 8'hff : next_tms_age;
  //////////////////////////////////////////////////////////////////////////
  // quiet flexible stretch: user drive must reach the clock and data-in pins
  sequence s_flex_idle;
    ($stable(i_user) && !i_fuse_prog && !o_test_active && !o_user_tdi)[*5];
  endsequence
  sequence s_sec_held;
    i_fuse_sec[*5];
  endsequence
  property p_mode;
    ($stable(i_fuse_prog))[*5] |-> o_dedicated == i_fuse_prog;
  endproperty
  property p_pull; o_pullup_en == o_dedicated; endproperty
  property p_ded; o_dedicated[*2] |-> !o_tck_oe && !o_tdi_oe; endproperty
  property p_flex;
    s_flex_idle |-> {o_tck_o, o_tck_oe, o_tdi_o, o_tdi_oe}
      == {i_user.clk_o, i_user.clk_oe, i_user.din_o, i_user.din_oe};
  endproperty
  property p_busy; (o_test_active || o_user_tdi) |-> !o_tck_oe && !o_tdi_oe;
  endproperty
  // dedicated mode raises the flag from the fuse alone, so flexible only
  property p_start;
    $rose(o_test_active) && !o_dedicated |-> tms_age < 8'h20;
  endproperty
  property p_sec; s_sec_held |-> !o_probe_out_a && !o_probe_out_b; endproperty
  property p_off; (!o_user_tdi)[*2] |-> !o_probe_out_a && !o_probe_out_b;
  endproperty
  a_mode: assert property (p_mode) else $error("mode flag off fuse");
  a_pull: assert property (p_pull) else $error("pull-up mismatch");
  a_ded: assert property (p_ded) else $error("user drive in dedicated");
  a_flex: assert property (p_flex) else $error("user drive lost");
  a_busy: assert property (p_busy) else $error("pins not taken");
  a_start: assert property (p_start) else $error("start without low");
  a_sec: assert property (p_sec) else $error("probe with fuse");
  a_off: assert property (p_off) else $error("probe while off");
endmodule // stp_mode_props
bind stp_mode_ctrl stp_mode_props u_props (.*);
`default_nettype wire

// ### verif/stp_tester.sv
// model: external scan tester driving select, data and link clock
`default_nettype none
module stp_tester (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi
);
  timeunit 1ns;
  timeprecision 1ps;
  // tms walk: reset to idle, ir scan, dr scan, back to idle
  localparam logic [24:0] WALK = {14'b01100000000001, 11'b01100000110};
  // link clock stands still between frames; select starts high and holds its last stepped value
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // one 48 ns link period, pins settled before the rise
  task automatic step(input logic m, input logic d);
    o_tms = m;
    o_tdi = d;
    #24 o_tck = 1'b1;
    #24 o_tck = 1'b0;
  endtask
  // five high selects park the port in reset
  task automatic quit();
    repeat (5) step(1'b1, 1'b1);
  endtask
  // probe instruction then selector, lsb first, ending in idle
  task automatic pick(input logic [8:0] dr);
    logic [24:0] d;
    d = {2'b11, dr, 5'h1f, stp_pkg::TAP_IR_PROBE, 5'h1f};
    for (int i = 0; i < 25; i++) step(WALK[i], d[i]);
  endtask
endmodule // stp_tester
`default_nettype wire

// ### verif/tb.sv
// bench: mode, pin sharing and probe routing of the scan port
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst, i_fuse_prog, i_fuse_sec, i_tck, i_tms, i_tdi;
  logic [15:0] i_nets;
  stp_pkg::stp_user_pins_t i_user;
  logic o_tdo, o_tdo_oe, o_tck_oe, o_tdi_o, o_tdi_oe, o_tck_o, o_pullup_en;
  logic o_dedicated, o_test_active, o_user_tdi, o_probe_out_a, o_probe_out_b;
  logic o_user_tck;
  int bad_count, num_checks;
  // rows: program fuse, user drive, expected pins
  logic [12:0] rows [5] = '{{1'b0, 6'h3f, 6'h3f}, {1'b0, 6'h15, 6'h15},
    {1'b0, 6'h2a, 6'h2a}, {1'b1, 6'h3f, 6'h00}, {1'b1, 6'h15, 6'h00}};
  logic [5:0] pins;
  assign pins = {o_tck_o, o_tck_oe, o_tdi_o, o_tdi_oe, o_tdo, o_tdo_oe};
  stp_mode_ctrl dut (.*);
  stp_tester tst (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi));
  always #2 i_clk = ~i_clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // main sequence; crossings settle within four cycles, six allowed
  initial begin
    {i_clk, i_rst, i_fuse_prog, i_fuse_sec} = 4'h6;
    {i_nets, i_user} = '0;
    clks(5);
    check({o_dedicated, o_pullup_en, o_test_active}, 8'h00, "reset");
    i_rst <= 1'b0;
    tst.quit();
    foreach (rows[k]) begin
      @(posedge i_clk) {i_fuse_prog, i_user} <= rows[k][12:6];
      clks(6);
      check({o_dedicated, o_pullup_en, o_test_active},
            {5'h00, rows[k][12], rows[k][12], rows[k][12]}, "mode");
      check(pins & (rows[k][12] ? 6'h3d : 6'h3f), rows[k][5:0], "pins");
    end
    // flexible probing takes the shared pins and routes nets 3 and 12
    @(posedge i_clk) {i_fuse_prog, i_nets} <= {1'b0, 16'h1008};
    tst.pick({1'b1, 4'h3, 4'hc});
    clks(6);
    check({o_test_active, o_user_tdi, o_tck_oe, o_tdi_oe, o_probe_out_a,
           o_probe_out_b}, 8'h33, "probe");
    @(posedge i_clk) i_nets <= 16'heff7;
    clks(6);
    check({o_probe_out_a, o_probe_out_b}, 8'h00, "follow");
    @(posedge i_clk) {i_fuse_sec, i_nets} <= {1'b1, 16'h1008};
    clks(6);
    check({o_probe_out_a, o_probe_out_b}, 8'h00, "secure");
    tst.quit();
    @(posedge i_clk) i_fuse_sec <= 1'b0;
    clks(6);
    check({o_test_active, o_user_tdi, pins}, 8'h15, "release");
    close_out();
  end
  // watchdog well past the expected few microseconds
  initial begin
    #20000;
    bad_count++;
    close_out();
  end
endmodule // tb
`default_nettype wire
